// ===== src/rmv_pkg.sv
// Constants, register map and carrier types for the rms and mean-absolute-value datapath
// What this block does
// - Square, low-pass filter, then square root
// - Seven channels in parallel, 24-bit results
// - Mean absolute value on three phase currents
// - Unsigned 24-bit current rms, 8 kHz refresh in normal power mode
// - Full-scale sine gives 0x3FF6A6, integrator off
// - Integrator bit 0 changes full-scale results
// - Settle within 440/550/500 ms
// - About 1.2 s settling after reset
// - Signal bandwidth of 2 kHz
// - Rms words read with upper byte zero
// - Offset times 128 added before root
// - Offset top nibble zero, sign-extended to 28
// - Mav path runs in both power modes
// - High-pass, absolute, average, unsigned 20-bit
// - Mav words read with upper twelve zero
package rmv_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 20_000_000;               // System clock rate
  localparam int DSP_RATE_HZ = 8_000;               // Computation cycle rate
  localparam int TICK_CYCLES = CLK_HZ / DSP_RATE_HZ; // Clocks per computation cycle
  localparam int TICK_W = 12;                       // Width of the rate divider

  // ----------------------------------------
  // Datapath shapes
  // ----------------------------------------
  localparam int NUM_CH = 7;          // Ia, Ib, Ic, In, Va, Vb, Vc
  localparam int NUM_CUR = 4;         // Channels carrying an offset register
  localparam int NUM_MAV = 3;         // Phase currents only
  localparam int SAMPLE_W = 24;       // Sample and rms width
  localparam int SQ_W = 48;           // Squared and mean-square width
  localparam int DSP_W = 28;          // Internal offset width
  localparam int MAV_W = 20;          // Mean absolute value width
  localparam int OFS_SHIFT = 7;       // Offset weight of 128
  localparam int LPF_SHIFT = 10;      // Mean-square filter pole
  localparam int INT_SHIFT = 4;       // Integrator leak
  localparam int HPF_SHIFT = 12;      // Dc removal pole of the mav path
  localparam int MAV_SHIFT = 10;      // Mav averaging pole
  localparam int MAV_DROP = 4;        // Low bits dropped for the 20-bit mav

  // ----------------------------------------
  // Register indices (word addresses)
  // ----------------------------------------
  localparam logic [3:0] ADDR_IA_RMS = 4'h0;   // phase_a_current_rms
  localparam logic [3:0] ADDR_IB_RMS = 4'h1;   // phase_b_current_rms
  localparam logic [3:0] ADDR_IC_RMS = 4'h2;   // phase_c_current_rms
  localparam logic [3:0] ADDR_IN_RMS = 4'h3;   // neutral_current_rms
  localparam logic [3:0] ADDR_VA_RMS = 4'h4;   // phase_a_voltage_rms
  localparam logic [3:0] ADDR_VB_RMS = 4'h5;   // phase_b_voltage_rms
  localparam logic [3:0] ADDR_VC_RMS = 4'h6;   // phase_c_voltage_rms
  localparam logic [3:0] ADDR_OFS_BASE = 4'h7; // Four offsets at 7..A
  localparam logic [3:0] ADDR_MAV_BASE = 4'hB; // Three mav results at B..D
  localparam logic [3:0] ADDR_CONFIG = 4'hE;   // Configuration
  localparam int CFG_INTEGRATOR_BIT = 0;       // integrator_enable_bit
  localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;

  // ----------------------------------------
  // Carrier types
  // ----------------------------------------
  typedef struct packed {
    logic [NUM_CH-1:0][SAMPLE_W-1:0] ch; // Signed samples, channel 0 is phase A current
  } rmv_samples_s;

  typedef struct packed {
    logic rd;          // Read strobe
    logic wr;          // Write strobe
    logic [3:0] addr;  // Word index
    logic [31:0] wdata; // Write data
  } rmv_reg_req_s;

endpackage

// ===== src/rmv_measure.sv
// Rms and mean-absolute-value measurement datapath with its register file
`timescale 1ns/1ns
module rmv_measure
(
  input wire logic clk,
  input wire logic rstn,
  input wire rmv_pkg::rmv_samples_s samples,
  input wire logic reduced_power_tamper_mode,
  input wire rmv_pkg::rmv_reg_req_s reg_req,
  output logic [31:0] reg_rdata,
  output logic results_ready
);
  import rmv_pkg::*;

  // ----------------------------------------
  // Computation-cycle divider
  // ----------------------------------------
  logic [TICK_W-1:0] div_q, div_d; // Rate counter
  logic tick_q, tick_d;            // One-cycle 8 kHz enable
  logic start_q, start_d;          // Delayed tick, filters already updated

  // Counts clocks and fires one enable per computation cycle
  always_comb
  begin
    start_d = tick_q;
    if (div_q == TICK_W'(TICK_CYCLES - 1))
    begin
      div_d = '0;
      tick_d = 1'b1;
    end
    else
    begin
      div_d = div_q + 1'b1;
      tick_d = 1'b0;
    end
  end

  // Registers the divider
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      div_q <= '0;
      tick_q <= 1'b0;
      start_q <= 1'b0;
    end
    else
    begin
      div_q <= div_d;
      tick_q <= tick_d;
      start_q <= start_d;
    end
  end

  // ----------------------------------------
  // Register file storage
  // ----------------------------------------
  logic [NUM_CUR-1:0][DSP_W-1:0] ofs_q; // Offsets, sign-extended
  logic integ_en_q;                     // integrator_enable_bit
  logic normal_power_mode;              // Rms filter and roots run only here
  assign normal_power_mode = !reduced_power_tamper_mode;

  // ----------------------------------------
  // Per-channel mean-square filters
  // ----------------------------------------
  logic [SQ_W-1:0] ms_q [NUM_CH]; // Filtered squares, one element per generate branch
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++)
    begin : g_ms
      logic signed [SAMPLE_W-1:0] int_q, int_d; // Leaky integrator state
      logic signed [SAMPLE_W-1:0] x;            // Sample entering the squarer
      logic [SQ_W-1:0] sq;                      // Squared sample
      logic signed [SQ_W:0] diff;               // Filter error term
      logic [SQ_W-1:0] ms_d;                    // Next mean square

      // Integrates current samples and runs the square and low-pass
      always_comb
      begin
        int_d = int_q;
        if (tick_q && gi < NUM_CUR)
        begin
          int_d = int_q - (int_q >>> INT_SHIFT) + ($signed(samples.ch[gi]) >>> INT_SHIFT);
        end
        // Current channels take the integrated signal when enabled
        if (gi < NUM_CUR && integ_en_q)
          x = int_q;
        else
          x = $signed(samples.ch[gi]);
        sq = SQ_W'(x * x);
        diff = $signed({1'b0, sq}) - $signed({1'b0, ms_q[gi]});
        ms_d = ms_q[gi];
        // Rms filter only runs in normal power mode
        if (tick_q && normal_power_mode)
          ms_d = ms_q[gi] + SQ_W'(diff >>> LPF_SHIFT);
      end

      // Registers integrator and filter
      always_ff @(posedge clk)
      begin
        if (!rstn)
        begin
          int_q <= '0;
          ms_q[gi] <= '0;
        end
        else
        begin
          int_q <= int_d;
          ms_q[gi] <= ms_d;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Mean-absolute-value path, phase currents only
  // ----------------------------------------
  logic [SAMPLE_W-1:0] mav_q [NUM_MAV]; // Averaged absolute values, one element per branch
  generate
    for (gi = 0; gi < NUM_MAV; gi++)
    begin : g_mav
      logic signed [SAMPLE_W:0] dc_q, dc_d; // Dc estimate
      logic signed [SAMPLE_W:0] hp;         // High-passed sample
      logic [SAMPLE_W-1:0] ab;              // Absolute value, clamped
      logic signed [SAMPLE_W:0] err;        // Average error term
      logic [SAMPLE_W-1:0] mav_d;           // Next average

      // High-pass, rectify and average in any power mode
      always_comb
      begin
        hp = $signed({samples.ch[gi][SAMPLE_W-1], samples.ch[gi]}) - dc_q;
        if (hp[SAMPLE_W])
          ab = (hp == {1'b1, {SAMPLE_W{1'b0}}}) ? '1 : SAMPLE_W'(-hp);
        else
          ab = hp[SAMPLE_W-1:0];
        err = $signed({1'b0, ab}) - $signed({1'b0, mav_q[gi]});
        dc_d = dc_q;
        mav_d = mav_q[gi];
        if (tick_q)
        begin
          dc_d = dc_q + (hp >>> HPF_SHIFT);
          mav_d = mav_q[gi] + SAMPLE_W'(err >>> MAV_SHIFT);
        end
      end

      // Registers dc estimate and average
      always_ff @(posedge clk)
      begin
        if (!rstn)
        begin
          dc_q <= '0;
          mav_q[gi] <= '0;
        end
        else
        begin
          dc_q <= dc_d;
          mav_q[gi] <= mav_d;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Square-root sequencer and result publication
  // ----------------------------------------
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_LOAD, SEQ_ROOT, SEQ_PUBLISH} rmv_seq_e;
  rmv_seq_e seq_q, seq_d;                   // Sequencer state
  logic [2:0] ch_q, ch_d;                   // Channel being rooted
  logic [4:0] bit_q, bit_d;                 // Root bit under trial
  logic [SQ_W-1:0] rad_q, rad_d;            // Radicand with offset
  logic [SAMPLE_W-1:0] root_q, root_d;      // Partial root
  logic [NUM_CH-1:0][SAMPLE_W-1:0] work_q, work_d; // Roots of this cycle
  logic [NUM_CH-1:0][SAMPLE_W-1:0] rms_q, rms_d;   // Published rms
  logic [NUM_MAV-1:0][MAV_W-1:0] mavr_q, mavr_d;   // Published mav
  logic rms_run_q, rms_run_d;               // Rms computed this cycle
  logic ready_q, ready_d;                   // Publication pulse
  logic signed [SQ_W+1:0] rad_sum;          // Mean square plus weighted offset
  logic [SAMPLE_W-1:0] trial;               // Candidate root
  logic [SQ_W-1:0] trial_sq;                // Candidate squared
  // Steps the roots channel by channel, then publishes everything at once
  always_comb
  begin
    seq_d = seq_q;
    ch_d = ch_q;
    bit_d = bit_q;
    rad_d = rad_q;
    root_d = root_q;
    work_d = work_q;
    rms_d = rms_q;
    mavr_d = mavr_q;
    rms_run_d = rms_run_q;
    ready_d = 1'b0;
    rad_sum = $signed({2'b00, ms_q[ch_q]});
    if (ch_q < 3'(NUM_CUR))
      rad_sum = rad_sum + $signed({{(SQ_W+2-DSP_W-OFS_SHIFT){ofs_q[ch_q[1:0]][DSP_W-1]}},
                                    ofs_q[ch_q[1:0]], {OFS_SHIFT{1'b0}}});
    trial = root_q | (SAMPLE_W'(1) << bit_q);
    trial_sq = trial * trial;
    unique case (seq_q)
      SEQ_IDLE:
      begin
        // Reduced power skips the rms roots but still publishes mav
        if (start_q)
        begin
          ch_d = '0;
          rms_run_d = normal_power_mode;
          seq_d = normal_power_mode ? SEQ_LOAD : SEQ_PUBLISH;
        end
      end
      SEQ_LOAD:
      begin
        // Negative sums clamp to zero, overflow saturates
        if (rad_sum[SQ_W+1])
          rad_d = '0;
        else if (rad_sum[SQ_W])
          rad_d = '1;
        else
          rad_d = rad_sum[SQ_W-1:0];
        root_d = '0;
        bit_d = 5'(SAMPLE_W - 1);
        seq_d = SEQ_ROOT;
      end
      SEQ_ROOT:
      begin
        // One result bit per clock, most significant first
        if (trial_sq <= rad_q)
          root_d = trial;
        if (bit_q == '0)
        begin
          work_d[ch_q] = (trial_sq <= rad_q) ? trial : root_q;
          if (ch_q == 3'(NUM_CH - 1))
            seq_d = SEQ_PUBLISH;
          else
          begin
            ch_d = ch_q + 1'b1;
            seq_d = SEQ_LOAD;
          end
        end
        else
          bit_d = bit_q - 1'b1;
      end
      SEQ_PUBLISH:
      begin
        // Mav results and, when rms_run_q is set, rms results change in the same clock
        if (rms_run_q)
          rms_d = work_q;
        for (int j = 0; j < NUM_MAV; j++)
          mavr_d[j] = mav_q[j][SAMPLE_W-1:MAV_DROP];
        ready_d = 1'b1;
        seq_d = SEQ_IDLE;
      end
    endcase
  end

  // Registers the sequencer and published results
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      seq_q <= SEQ_IDLE;
      ch_q <= '0;
      bit_q <= '0;
      rad_q <= '0;
      root_q <= '0;
      work_q <= '0;
      rms_q <= '0;
      mavr_q <= '0;
      rms_run_q <= 1'b0;
      ready_q <= 1'b0;
    end
    else
    begin
      seq_q <= seq_d;
      ch_q <= ch_d;
      bit_q <= bit_d;
      rad_q <= rad_d;
      root_q <= root_d;
      work_q <= work_d;
      rms_q <= rms_d;
      mavr_q <= mavr_d;
      rms_run_q <= rms_run_d;
      ready_q <= ready_d;
    end
  end

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  logic [NUM_CUR-1:0][DSP_W-1:0] ofs_d; // Next offsets
  logic integ_en_d;                     // Next integrator enable
  logic [31:0] rdata_q, rdata_d;        // Read data, held until next read
  // Decodes the word index into read data and register writes
  always_comb
  begin
    ofs_d = ofs_q;
    integ_en_d = integ_en_q;
    rdata_d = rdata_q;
    if (reg_req.wr)
    begin
      if (reg_req.addr >= ADDR_OFS_BASE && reg_req.addr < ADDR_OFS_BASE + 4'(NUM_CUR))
        ofs_d[2'(reg_req.addr - ADDR_OFS_BASE)] =
          {{(DSP_W-SAMPLE_W){reg_req.wdata[SAMPLE_W-1]}}, reg_req.wdata[SAMPLE_W-1:0]};
      else if (reg_req.addr == ADDR_CONFIG)
        integ_en_d = reg_req.wdata[CFG_INTEGRATOR_BIT];
    end
    if (reg_req.rd)
    begin
      // Unmapped indices read as zero
      rdata_d = '0;
      if (reg_req.addr <= ADDR_VC_RMS)
        rdata_d = {8'h00, rms_q[3'(reg_req.addr)]};
      else if (reg_req.addr < ADDR_MAV_BASE)
        rdata_d = {4'h0, ofs_q[2'(reg_req.addr - ADDR_OFS_BASE)]};
      else if (reg_req.addr < ADDR_CONFIG)
        rdata_d = {12'h000, mavr_q[2'(reg_req.addr - ADDR_MAV_BASE)]};
      else if (reg_req.addr == ADDR_CONFIG)
        rdata_d = CONFIG_RESET | (32'(integ_en_q) << CFG_INTEGRATOR_BIT);
    end
  end

  // Registers offsets, configuration and read data
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      ofs_q <= '0;
      integ_en_q <= CONFIG_RESET[CFG_INTEGRATOR_BIT];
      rdata_q <= '0;
    end
    else
    begin
      ofs_q <= ofs_d;
      integ_en_q <= integ_en_d;
      rdata_q <= rdata_d;
    end
  end
  assign reg_rdata = rdata_q;
  assign results_ready = ready_q;
endmodule

// ===== verification/rmv_measure_props.sv
// Checker for the register port and publish timing of rmv_measure
`timescale 1ns/1ns
module rmv_measure_props
(
  input wire logic clk,
  input wire logic rstn,
  input wire rmv_pkg::rmv_samples_s samples,
  input wire logic reduced_power_tamper_mode,
  input wire rmv_pkg::rmv_reg_req_s reg_req,
  input wire logic [31:0] reg_rdata,
  input wire logic results_ready
);
  import rmv_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // ----------------------------------------
  // Publish spacing helper
  // ----------------------------------------
  logic [11:0] gap_q; // Cycles since the last publish
  logic [11:0] gap_d;
  logic seen_q; // A publish has been seen
  logic seen_d;
  logic mode_q; // Mode at the last publish
  logic mode_d;
  // Next values of the spacing helper
  always_comb
  begin
    gap_d = results_ready ? 12'h001 : gap_q + 12'h001;
    seen_d = rstn && (seen_q || results_ready);
    mode_d = results_ready ? reduced_power_tamper_mode : mode_q;
    if (!rstn)
    begin
      gap_d = 12'h000;
    end
  end
  // Register the spacing helper
  always_ff @(posedge clk)
  begin
    gap_q <= gap_d;
    seen_q <= seen_d;
    mode_q <= mode_d;
  end
  // ----------------------------------------
  // Sequences and properties
  // ----------------------------------------
  sequence s_ofs_write;
    reg_req.wr && reg_req.addr inside {[4'h7:4'hA]};
  endsequence
  sequence s_same_read;
    reg_req.rd && !reg_req.wr && reg_req.addr == $past(reg_req.addr, 2);
  endsequence
  AST_RESET_QUIET: assert property ($past(!rstn) |-> reg_rdata == 32'h0 && !results_ready)
    else $error("read data or publish active after reset");
  AST_PUBLISH_PULSE: assert property (results_ready |=> (!results_ready)[*8])
    else $error("publish pulse too long or too close");
  AST_PUBLISH_RATE: assert property (results_ready && seen_q &&
    mode_q == reduced_power_tamper_mode |-> gap_q == TICK_CYCLES)
    else $error("publish spacing is not one computation cycle");
  AST_UNMAPPED_ZERO: assert property (reg_req.rd && reg_req.addr == 4'hF |=> reg_rdata == 32'h0)
    else $error("unmapped read returned data");
  AST_RMS_UPPER: assert property (reg_req.rd && reg_req.addr <= 4'h6 |=> reg_rdata[31:24] == 8'h00)
    else $error("rms word upper byte not zero");
  AST_MAV_UPPER: assert property (reg_req.rd && reg_req.addr inside {[4'hB:4'hD]}
    |=> reg_rdata[31:20] == 12'h000)
    else $error("mav word upper bits not zero");
  AST_OFS_FORMAT: assert property (reg_req.rd && reg_req.addr inside {[4'h7:4'hA]}
    |=> reg_rdata[31:28] == 4'h0 && reg_rdata[27:24] == {4{reg_rdata[23]}})
    else $error("offset word not sign extended to 28 bits");
  AST_RDATA_HOLD: assert property (!reg_req.rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");
  AST_OFS_READBACK: assert property (s_ofs_write ##1 !reg_req.wr ##1 s_same_read
    |=> reg_rdata[23:0] == $past(reg_req.wdata[23:0], 3))
    else $error("offset readback differs from written value");
endmodule
bind rmv_measure rmv_measure_props u_props (.clk(clk), .rstn(rstn), .samples(samples),
  .reduced_power_tamper_mode(reduced_power_tamper_mode), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .results_ready(results_ready));

// ===== verification/rmv_host.sv
// Host model issuing whole-word reads and writes on the register port
`timescale 1ns/1ns
module rmv_host
(
  input wire logic clk,
  output rmv_pkg::rmv_reg_req_s reg_req
);
  import rmv_pkg::*;
  // Idle port at time zero
  initial reg_req = '0;
  // Read strobe for one sampling edge, then address scrambled
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_req.addr <= a;
    reg_req.rd <= 1'b1;
    @(posedge clk);
    reg_req.rd <= 1'b0;
    reg_req.addr <= ~a;
  endtask
  // Write strobe for one sampling edge, then data scrambled
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_req.addr <= a;
    reg_req.wdata <= d;
    reg_req.wr <= 1'b1;
    @(posedge clk);
    reg_req.wr <= 1'b0;
    reg_req.addr <= ~a;
    reg_req.wdata <= ~d;
  endtask
endmodule

// ===== verification/tb.sv
// Self-checking bench for the rms and mav measurement block
`timescale 1ns/1ns
module tb;
  import rmv_pkg::*;
  typedef struct packed {
    logic [31:0] exp;
    logic [31:0] mask;
    logic nz;
  } rmv_note_s;
  logic clk = 1'b0; // 20 MHz clock
  logic rstn = 1'b0;
  rmv_samples_s samples = '0;
  logic reduced_power_tamper_mode = 1'b0;
  logic ac_on = 1'b0; // Square wave on the current channels
  rmv_reg_req_s reg_req;
  logic [31:0] reg_rdata;
  logic results_ready;
  rmv_note_s notes[$]; // Expected read results, oldest first
  logic rd_seen = 1'b0;
  int n_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [23:0] d24;
  always #25 clk = ~clk;
  rmv_measure DUT (.clk(clk), .rstn(rstn), .samples(samples),
    .reduced_power_tamper_mode(reduced_power_tamper_mode), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .results_ready(results_ready));
  rmv_host host (.clk(clk), .reg_req(reg_req));
  // Flip the sign of the current samples at each publish
  always @(posedge clk)
  begin
    if (ac_on && results_ready === 1'b1)
    begin
      for (int i = 0; i < NUM_CUR; i++)
      begin
        samples.ch[i] <= samples.ch[0][23] ? 24'h400000 : 24'hC00000;
      end
    end
  end
  // Compare each read result with the oldest note
  always @(posedge clk)
  begin
    rmv_note_s nt;
    if (rd_seen)
    begin
      nt = notes.pop_front();
      n_compared++;
      if ((reg_rdata & nt.mask) !== nt.exp || (nt.nz && (reg_rdata & ~nt.mask) === 32'h0))
      begin
        $display("BAD t=%0t exp=%h got=%h", $time, nt.exp, reg_rdata);
        n_errors++;
      end
    end
    rd_seen <= reg_req.rd;
  end
  // Cut a hang short
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      n_errors++;
      tally_and_finish();
    end
  end
  // Note the expectation, then read
  task automatic chk(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m,
    input logic nz);
    notes.push_back('{e, m, nz});
    host.rd(a);
  endtask
  // Wait for n publishes under a bound
  task automatic wait_rdy(input int n);
    int k;
    for (int i = 0; i < n; i++)
    begin
      k = 0;
      do
      begin
        @(posedge clk);
        k++;
      end while (results_ready !== 1'b1 && k < 3000);
      if (k >= 3000)
      begin
        $display("BAD t=%0t exp=%h got=%h", $time, 1'b1, results_ready);
        n_errors++;
      end
    end
  endtask
  // Print counts and the verdict
  task automatic tally_and_finish();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    void'($urandom(81123));
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    for (int a = 0; a < 16; a++)
    begin
      chk(a[3:0], 32'h0, 32'hFFFFFFFF, 1'b0);
    end
    host.wr(4'h0, 32'h00FFFFFF);
    host.wr(4'hF, 32'h00FFFFFF);
    chk(4'h0, 32'h0, 32'hFFFFFFFF, 1'b0);
    chk(4'hF, 32'h0, 32'hFFFFFFFF, 1'b0);
    for (int i = 0; i < NUM_CUR; i++)
    begin
      d24 = 24'($urandom());
      d24[23] = i[0];
      host.wr(ADDR_OFS_BASE + i[3:0], {8'h00, d24});
      chk(ADDR_OFS_BASE + i[3:0], {4'h0, {4{d24[23]}}, d24}, 32'hFFFFFFFF, 1'b0);
    end
    host.wr(ADDR_CONFIG, 32'h1);
    chk(ADDR_CONFIG, 32'h1, 32'hFFFFFFFF, 1'b0);
    host.wr(ADDR_CONFIG, 32'h0);
    // Small non-zero current on phase C while the offsets are set
    samples.ch[2] <= 24'h000100;
    host.wr(ADDR_OFS_BASE, 32'h00000200);
    host.wr(ADDR_OFS_BASE + 4'h1, 32'h00FFFE00);
    host.wr(ADDR_OFS_BASE + 4'h2, 32'h0);
    host.wr(ADDR_OFS_BASE + 4'h3, 32'h0);
    wait_rdy(2);
    chk(ADDR_IA_RMS, 32'h100, 32'hFFFFFFFF, 1'b0);
    chk(ADDR_IB_RMS, 32'h0, 32'hFFFFFFFF, 1'b0);
    chk(ADDR_VA_RMS, 32'h0, 32'hFFFFFFFF, 1'b0);
    reduced_power_tamper_mode <= 1'b1;
    samples.ch[0] <= 24'h400000;
    ac_on <= 1'b1;
    wait_rdy(10);
    chk(ADDR_IA_RMS, 32'h100, 32'hFFFFFFFF, 1'b0);
    for (int i = 0; i < NUM_MAV; i++)
    begin
      chk(ADDR_MAV_BASE + i[3:0], 32'h0, 32'hFFF00000, 1'b1);
    end
    reduced_power_tamper_mode <= 1'b0;
    wait_rdy(4);
    chk(ADDR_IA_RMS, 32'h0, 32'hFF000000, 1'b1);
    chk(ADDR_IN_RMS, 32'h0, 32'hFF000000, 1'b1);
    chk(ADDR_VA_RMS, 32'h0, 32'hFFFFFFFF, 1'b0);
    chk(ADDR_MAV_BASE, 32'h0, 32'hFFF00000, 1'b1);
    // Mid-run reset, then a dc current through the integrator and the plain path
    ac_on <= 1'b0;
    samples.ch[0] <= 24'h100000;
    rstn <= 1'b0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    host.wr(ADDR_CONFIG, 32'h1);
    chk(ADDR_IA_RMS, 32'h0, 32'hFFFFFFFF, 1'b0);
    wait_rdy(1);
    // Integrator starts from zero, so the first filtered square is zero
    chk(ADDR_IA_RMS, 32'h0, 32'hFFFFFFFF, 1'b0);
    host.wr(ADDR_CONFIG, 32'h0);
    wait_rdy(1);
    // One filter step of 0x100000 squared gives 2^30, whose root is 0x8000
    chk(ADDR_IA_RMS, 32'h8000, 32'hFFFFFFFF, 1'b0);
    repeat (3) @(posedge clk);
    tally_and_finish();
  end
endmodule
